// ### logic/mcc_pkg.sv
// Purpose: Shared constants and types for the meter configuration control.
// Assumes: 100 MHz core clock, AXI4-Lite register access, 32-bit data.
// Notes:   One configuration word plus one read-only status word.
`default_nettype none
package mcc_pkg;
    // Clock rate used to turn times into cycle counts
    localparam int unsigned CORE_CLK_KHZ    = 100000;
    // Filter settling times in milliseconds
    localparam int unsigned SETTLE_SHORT_MS = 650;
    localparam int unsigned SETTLE_LONG_MS  = 1300;
    localparam int unsigned SETTLE_SHORT_CYC = SETTLE_SHORT_MS * CORE_CLK_KHZ;
    localparam int unsigned SETTLE_LONG_CYC  = SETTLE_LONG_MS * CORE_CLK_KHZ;
    // Length of the soft reset sequence in cycles
    localparam logic [4:0]  SRST_CYCLES     = 5'h10;

    // Register byte addresses
    localparam logic [7:0]  ADDR_GEN_CFG    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS     = 8'h04;

    // Field positions in the configuration word
    localparam int unsigned FLD_SETTLE      = 5;
    localparam int unsigned FLD_CAPTURE_EN  = 6;
    localparam int unsigned FLD_SRST        = 7;
    localparam int unsigned FLD_PICK_A      = 8;
    localparam int unsigned FLD_PICK_B      = 10;
    localparam int unsigned FLD_PICK_C      = 12;
    localparam int unsigned FLD_NEUTRAL     = 14;
    localparam int unsigned FLD_RSVD        = 15;

    // Status word bit positions
    localparam int unsigned STS_SETTLED     = 0;
    localparam int unsigned STS_SRST_BUSY   = 1;
    localparam int unsigned STS_CAPTURE     = 2;

    // Value after reset of the configuration word
    localparam logic [15:0] GEN_CFG_RESET   = 16'h0010;

    // AXI response codes
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Configuration word layout, bit 15 down to bit 0
    typedef struct packed {
        logic       reserved_top;
        logic       neutral_source_select;
        logic [1:0] phase_c_voltage_pick;
        logic [1:0] phase_b_voltage_pick;
        logic [1:0] phase_a_voltage_pick;
        logic       soft_reset_trigger;
        logic       fast_capture_port_enable;
        logic       filter_settle_select;
        logic [4:0] lower_fields;
    } mcc_cfg_t;

    // Resolved voltage source per phase current: 0 = A, 1 = B, 2 = C
    typedef logic [2:0][1:0] mcc_pair_t;
endpackage : mcc_pkg
`default_nettype wire

// ### logic/mcc_settle_timer.sv
// Purpose: Times the settling of the active power low-pass filter.
// Assumes: Restart is a level held while the filter is being reset.
// Notes:   Counts are parameters so that simulation can shorten them.
`timescale 1ns/1ns
`default_nettype none
module mcc_settle_timer #(
    parameter int unsigned SHORT_CYC = mcc_pkg::SETTLE_SHORT_CYC,
    parameter int unsigned LONG_CYC  = mcc_pkg::SETTLE_LONG_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic restart,
    input  wire logic sel,
    output var  logic settled
);
    import mcc_pkg::*;

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        sel_prev_ff;
    logic        settled_ff;
    logic        nxt_settled;

    always_comb begin
        nxt_cnt     = cnt_ff;
        nxt_settled = settled_ff;
        if (restart || (sel != sel_prev_ff)) begin
            nxt_cnt     = sel ? LONG_CYC : SHORT_CYC;
            nxt_settled = 1'b0;
        end else if (cnt_ff > 32'h1) begin
            nxt_cnt = cnt_ff - 32'h1;
        end else begin
            nxt_cnt     = 32'h0;
            nxt_settled = 1'b1;
        end
    end

    // Timer registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff      <= SHORT_CYC;
            sel_prev_ff <= 1'b0;
            settled_ff  <= 1'b0;
        end else begin
            cnt_ff      <= nxt_cnt;
            sel_prev_ff <= sel;
            settled_ff  <= nxt_settled;
        end
    end

    assign settled = settled_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_settle_restart_clears: assert property (
        (restart || sel != sel_prev_ff) |=> !settled_ff)
        else $error("Settled flag survived a restart");
endmodule : mcc_settle_timer
`default_nettype wire

// ### logic/mcc_phase_pair.sv
// Purpose: Resolves which phase voltage pairs with each phase current.
// Assumes: Pick codes come straight from the configuration word.
// Notes:   Output is registered, one cycle behind the pick codes.
`timescale 1ns/1ns
`default_nettype none
module mcc_phase_pair (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire mcc_pkg::mcc_pair_t picks,
    output var  mcc_pkg::mcc_pair_t srcs
);
    import mcc_pkg::*;

    mcc_pair_t src_ff;
    mcc_pair_t nxt_src;

    for (genvar p = 0; p < 3; p++) begin : g_phase
        always_comb begin
            if (picks[p] == 2'h3) begin
                nxt_src[p] = 2'(p);
            end else begin
                nxt_src[p] = 2'((p + int'(picks[p])) % 3);
            end
        end
    end

    // Source registers
    always_ff @(posedge clk) begin
        if (rst) begin
            src_ff <= '0;
        end else begin
            src_ff <= nxt_src;
        end
    end

    assign srcs = src_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_pick_a_phase_b: assert property (
        picks[0] == 2'h1 |=> src_ff[0] == 2'h1)
        else $error("Phase A pick 01 did not select phase B");
    chk_pick_b_phase_a: assert property (
        picks[1] == 2'h2 |=> src_ff[1] == 2'h0)
        else $error("Phase B pick 10 did not select phase A");
    chk_pick_c_reserved: assert property (
        picks[2] == 2'h3 |=> src_ff[2] == 2'h2)
        else $error("Phase C pick 11 did not act as 00");
endmodule : mcc_phase_pair
`default_nettype wire

// ### logic/mcc_config_ctrl.sv
// Purpose: Configuration register of the metering core behind AXI4-Lite.
// Assumes: Single clock, synchronous active-high reset, 32-bit bus.
// Notes:   Configuration at byte 0x00, read-only status at byte 0x04.
`timescale 1ns/1ns
`default_nettype none
module mcc_config_ctrl #(
    parameter int unsigned SETTLE_SHORT = mcc_pkg::SETTLE_SHORT_CYC,
    parameter int unsigned SETTLE_LONG  = mcc_pkg::SETTLE_LONG_CYC
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output var  logic        S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output var  logic        S_AXI_WREADY,
    output var  logic [1:0]  S_AXI_BRESP,
    output var  logic        S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output var  logic        S_AXI_ARREADY,
    output var  logic [31:0] S_AXI_RDATA,
    output var  logic [1:0]  S_AXI_RRESP,
    output var  logic        S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        THIRD_PULSE_OUTPUT_IN,
    input  wire logic        CAPTURE_PORT_CLOCK_IN,
    output var  logic        SHARED_PIN_OUT,
    output var  logic        FAST_CAPTURE_PORT_EN,
    output var  logic        SOFT_RESET_ACTIVE,
    output var  logic        FILTER_SETTLE_SELECT,
    output var  logic        FILTER_SETTLED,
    output var  mcc_pkg::mcc_pair_t PHASE_VOLTAGE_SRC,
    output var  logic        NEUTRAL_SOURCE_SELECT
);
    import mcc_pkg::*;

    // Bus holding registers
    logic        aw_hold_ff, nxt_aw_hold;
    logic [7:0]  awaddr_ff, nxt_awaddr;
    logic        w_hold_ff, nxt_w_hold;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0]  wstrb_ff, nxt_wstrb;
    logic        awready_ff, nxt_awready;
    logic        wready_ff, nxt_wready;
    logic        bvalid_ff, nxt_bvalid;
    logic [1:0]  bresp_ff, nxt_bresp;
    logic        arready_ff, nxt_arready;
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0]  rresp_ff, nxt_rresp;

    // Configuration and soft reset state
    mcc_cfg_t    cfg_ff, nxt_cfg;
    logic        srst_busy_ff, nxt_srst_busy;
    logic [4:0]  srst_cnt_ff, nxt_srst_cnt;
    logic        pin_ff, nxt_pin;
    logic        cap_en_ff, nxt_cap_en;

    logic        settled;
    logic        do_write;
    logic [15:0] wr_word;
    logic [15:0] cfg_rd;

    assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;

    // Merge byte lanes of the write into the current word
    always_comb begin
        wr_word = cfg_ff;
        if (wstrb_ff[0]) begin
            wr_word[7:0] = wdata_ff[7:0];
        end
        if (wstrb_ff[1]) begin
            wr_word[15:8] = wdata_ff[15:8];
        end
    end

    // Configuration readback, trigger bit shows the reset in progress
    always_comb begin
        cfg_rd           = cfg_ff;
        cfg_rd[FLD_SRST] = srst_busy_ff;
    end

    // Write channel: hold address and data, answer once both are in
    always_comb begin
        nxt_aw_hold = aw_hold_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_w_hold  = w_hold_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        if (S_AXI_AWVALID && awready_ff) begin
            nxt_aw_hold = 1'b1;
            nxt_awaddr  = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && wready_ff) begin
            nxt_w_hold = 1'b1;
            nxt_wdata  = S_AXI_WDATA;
            nxt_wstrb  = S_AXI_WSTRB;
        end
        if (do_write) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = (awaddr_ff == ADDR_GEN_CFG ||
                           awaddr_ff == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_ff && S_AXI_BREADY) begin
            nxt_bvalid = 1'b0;
        end
        nxt_awready = !nxt_aw_hold && !nxt_bvalid;
        nxt_wready  = !nxt_w_hold && !nxt_bvalid;
    end

    // Read channel: one-cycle answer from the register map
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (S_AXI_ARVALID && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = 32'h0;
            nxt_rresp  = RESP_OKAY;
            case (S_AXI_ARADDR)
                ADDR_GEN_CFG: begin
                    nxt_rdata = {16'h0, cfg_rd};
                end
                ADDR_STATUS: begin
                    nxt_rdata[STS_SETTLED]   = settled;
                    nxt_rdata[STS_SRST_BUSY] = srst_busy_ff;
                    nxt_rdata[STS_CAPTURE]   = cap_en_ff;
                end
                default: begin
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && S_AXI_RREADY) begin
            nxt_rvalid = 1'b0;
        end
        nxt_arready = !nxt_rvalid;
    end

    // Configuration word and soft reset sequence
    always_comb begin
        nxt_cfg       = cfg_ff;
        nxt_srst_busy = srst_busy_ff;
        nxt_srst_cnt  = srst_cnt_ff;
        if (srst_busy_ff) begin
            if (srst_cnt_ff == 5'h1) begin
                nxt_cfg       = GEN_CFG_RESET;
                nxt_srst_busy = 1'b0;
                nxt_srst_cnt  = 5'h0;
            end else begin
                nxt_srst_cnt = srst_cnt_ff - 5'h1;
            end
        end else if (do_write && awaddr_ff == ADDR_GEN_CFG) begin
            nxt_cfg = wr_word;
            nxt_cfg.soft_reset_trigger = 1'b0;
            if (wr_word[FLD_SRST]) begin
                nxt_srst_busy = 1'b1;
                nxt_srst_cnt  = SRST_CYCLES;
            end
        end
    end

    // Shared pin and capture port enable
    always_comb begin
        nxt_cap_en = cfg_ff.fast_capture_port_enable;
        if (cfg_ff.fast_capture_port_enable) begin
            nxt_pin = CAPTURE_PORT_CLOCK_IN;
        end else begin
            nxt_pin = THIRD_PULSE_OUTPUT_IN;
        end
    end

    // Register everything
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            aw_hold_ff   <= 1'b0;
            awaddr_ff    <= 8'h0;
            w_hold_ff    <= 1'b0;
            wdata_ff     <= 32'h0;
            wstrb_ff     <= 4'h0;
            awready_ff   <= 1'b1;
            wready_ff    <= 1'b1;
            bvalid_ff    <= 1'b0;
            bresp_ff     <= RESP_OKAY;
            arready_ff   <= 1'b1;
            rvalid_ff    <= 1'b0;
            rdata_ff     <= 32'h0;
            rresp_ff     <= RESP_OKAY;
            cfg_ff       <= GEN_CFG_RESET;
            srst_busy_ff <= 1'b0;
            srst_cnt_ff  <= 5'h0;
            pin_ff       <= 1'b0;
            cap_en_ff    <= 1'b0;
        end else begin
            aw_hold_ff   <= nxt_aw_hold;
            awaddr_ff    <= nxt_awaddr;
            w_hold_ff    <= nxt_w_hold;
            wdata_ff     <= nxt_wdata;
            wstrb_ff     <= nxt_wstrb;
            awready_ff   <= nxt_awready;
            wready_ff    <= nxt_wready;
            bvalid_ff    <= nxt_bvalid;
            bresp_ff     <= nxt_bresp;
            arready_ff   <= nxt_arready;
            rvalid_ff    <= nxt_rvalid;
            rdata_ff     <= nxt_rdata;
            rresp_ff     <= nxt_rresp;
            cfg_ff       <= nxt_cfg;
            srst_busy_ff <= nxt_srst_busy;
            srst_cnt_ff  <= nxt_srst_cnt;
            pin_ff       <= nxt_pin;
            cap_en_ff    <= nxt_cap_en;
        end
    end

    mcc_settle_timer #(
        .SHORT_CYC (SETTLE_SHORT),
        .LONG_CYC  (SETTLE_LONG)
    ) u_settle (
        .clk     (CORE_CLK),
        .rst     (RST),
        .restart (srst_busy_ff),
        .sel     (cfg_ff.filter_settle_select),
        .settled (settled)
    );

    mcc_phase_pair u_pair (
        .clk   (CORE_CLK),
        .rst   (RST),
        .picks ({cfg_ff.phase_c_voltage_pick, cfg_ff.phase_b_voltage_pick,
                 cfg_ff.phase_a_voltage_pick}),
        .srcs  (PHASE_VOLTAGE_SRC)
    );

    // Port drive, all from flip-flops
    assign S_AXI_AWREADY         = awready_ff;
    assign S_AXI_WREADY          = wready_ff;
    assign S_AXI_BVALID          = bvalid_ff;
    assign S_AXI_BRESP           = bresp_ff;
    assign S_AXI_ARREADY         = arready_ff;
    assign S_AXI_RVALID          = rvalid_ff;
    assign S_AXI_RDATA           = rdata_ff;
    assign S_AXI_RRESP           = rresp_ff;
    assign SHARED_PIN_OUT        = pin_ff;
    assign FAST_CAPTURE_PORT_EN  = cap_en_ff;
    assign SOFT_RESET_ACTIVE     = srst_busy_ff;
    assign FILTER_SETTLE_SELECT  = cfg_ff.filter_settle_select;
    assign FILTER_SETTLED        = settled;
    assign NEUTRAL_SOURCE_SELECT = cfg_ff.neutral_source_select;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    // Committed config write; extra narrows it to a lane or field value
    sequence s_cfg_write(logic b, logic extra);
        do_write && awaddr_ff == ADDR_GEN_CFG && !srst_busy_ff &&
        wstrb_ff[0] && wdata_ff[FLD_SRST] == b && extra;
    endsequence
    sequence s_srst_run;
        srst_busy_ff [*8] ##1 srst_busy_ff [*8];
    endsequence

    chk_settle_sel_bit: assert property (
        s_cfg_write(1'b0, 1'b1) |=>
        FILTER_SETTLE_SELECT == wdata_ff[FLD_SETTLE] || !wstrb_ff[0])
        else $error("Settle select did not follow bit 5");
    chk_pin_pulse: assert property (
        !cfg_ff.fast_capture_port_enable |=>
        SHARED_PIN_OUT == $past(THIRD_PULSE_OUTPUT_IN) && !FAST_CAPTURE_PORT_EN)
        else $error("Pulse output not on shared pin");
    chk_pin_clock: assert property (
        cfg_ff.fast_capture_port_enable |=>
        SHARED_PIN_OUT == $past(CAPTURE_PORT_CLOCK_IN) && FAST_CAPTURE_PORT_EN)
        else $error("Capture clock not on shared pin");
    chk_srst_start: assert property (
        s_cfg_write(1'b1, 1'b1) |=> s_srst_run ##1 !srst_busy_ff)
        else $error("Soft reset did not run for its length");
    chk_srst_defaults: assert property (
        $fell(srst_busy_ff) |-> cfg_ff == GEN_CFG_RESET && !cfg_rd[FLD_SRST])
        else $error("Defaults not restored after soft reset");
    chk_neutral_sel: assert property (
        s_cfg_write(1'b0, wstrb_ff[1]) |=>
        NEUTRAL_SOURCE_SELECT == $past(wdata_ff[FLD_NEUTRAL]))
        else $error("Neutral select did not follow bit 14");
    chk_neutral_sum: assert property (
        s_cfg_write(1'b0, wstrb_ff[1] && wdata_ff[FLD_NEUTRAL]) |=>
        NEUTRAL_SOURCE_SELECT [*2])
        else $error("Neutral sum select lost");
    chk_rsvd_inert: assert property (
        $changed(cfg_ff.reserved_top) && !$changed(cfg_ff[14:0]) |=>
        $stable(PHASE_VOLTAGE_SRC) && $stable(FAST_CAPTURE_PORT_EN))
        else $error("Reserved bit changed behaviour");
    chk_pair_follow: assert property (
        s_cfg_write(1'b0, wstrb_ff[1] && wdata_ff[9:8] == 2'h2) |=> ##1
        PHASE_VOLTAGE_SRC[0] == 2'h2)
        else $error("Phase A pick 10 did not reach phase C");
endmodule : mcc_config_ctrl
`default_nettype wire

// ### tb/meter_config_control_test.sv
// Purpose: Self-checking bench for the meter configuration control block.
// Assumes: Settle counts shortened to 20 and 40 cycles for simulation.
// Notes:   Driver queues expected bus answers; a monitor compares them.
`timescale 1ns/1ns
`default_nettype none
module meter_config_control_test;
    import mcc_pkg::*;
    localparam int unsigned S_SHORT = 20;
    localparam int unsigned S_LONG  = 40;
    logic        clk = 1'b0, rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        pulse_in = 1'b0, cap_in = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, shared_pin;
    logic        cap_en, soft_act, settle_sel, settled, neutral_sel;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    mcc_pair_t   phase_src;
    int          err_total = 0, check_count = 0;
    logic [33:0] r_q[$];
    logic [1:0]  b_q[$];
    logic [33:0] r_exp;
    logic [1:0]  b_exp;

    mcc_config_ctrl #(.SETTLE_SHORT(S_SHORT), .SETTLE_LONG(S_LONG))
    i_mcc_config_ctrl (
        .CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .THIRD_PULSE_OUTPUT_IN(pulse_in),
        .CAPTURE_PORT_CLOCK_IN(cap_in), .SHARED_PIN_OUT(shared_pin),
        .FAST_CAPTURE_PORT_EN(cap_en), .SOFT_RESET_ACTIVE(soft_act),
        .FILTER_SETTLE_SELECT(settle_sel), .FILTER_SETTLED(settled),
        .PHASE_VOLTAGE_SRC(phase_src), .NEUTRAL_SOURCE_SELECT(neutral_sel)
    );

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic close_out();
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // Expected voltage source per phase and code, code 3 acts as code 0
    function automatic logic [1:0] pick_src(input int ph,
                                            input logic [1:0] c);
        logic [1:0] tbl [3][4];
        tbl = '{'{2'h0, 2'h1, 2'h2, 2'h0}, '{2'h1, 2'h2, 2'h0, 2'h1},
                '{2'h2, 2'h0, 2'h1, 2'h2}};
        return tbl[ph][c];
    endfunction : pick_src

    // Write with address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        bit aw_done, w_done;
        @(posedge clk);
        b_q.push_back(er);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_done = 1'b0;
        w_done  = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge clk);
        r_q.push_back({er, ed});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        rready <= 1'b0;
    endtask : rd

    // Monitor: oldest note compared at each response handshake
    always @(posedge clk) begin
        if (!rst && rvalid === 1'b1 && rready) begin
            r_exp = r_q.pop_front();
            chk("read_data", r_exp[31:0], rdata);
            chk("read_resp", 32'(r_exp[33:32]), 32'(rresp));
        end
        if (!rst && bvalid === 1'b1 && bready) begin
            b_exp = b_q.pop_front();
            chk("write_resp", 32'(b_exp), 32'(bresp));
        end
    end

    // Filter settle select and the elapsed time to the settled flag
    task automatic settle_chk(input logic sel, input int unsigned cyc);
        int n;
        wr(ADDR_GEN_CFG, {16'h0, GEN_CFG_RESET | (16'(sel) << FLD_SETTLE)},
           4'h3, RESP_OKAY);
        n = 0;
        while (settled === 1'b1 && n < 5) begin
            @(posedge clk);
            n++;
        end
        while (settled !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk("settle_sel", 32'(sel), 32'(settle_sel));
        chk("settle_time", 32'h1, 32'(n >= cyc - 2 && n <= cyc + 8));
    endtask : settle_chk

    // Shared pin follows the chosen source one clock later
    task automatic pin_chk(input logic sel);
        logic p, c;
        wr(ADDR_GEN_CFG, {16'h0, GEN_CFG_RESET | (16'(sel) << FLD_CAPTURE_EN)},
           4'h3, RESP_OKAY);
        repeat (6) begin
            @(posedge clk);
            p = 1'($urandom);
            c = 1'($urandom);
            pulse_in <= p;
            cap_in   <= c;
            @(posedge clk);
            @(negedge clk);
            chk("shared_pin", 32'(sel ? c : p), 32'(shared_pin));
            chk("capture_en", 32'(sel), 32'(cap_en));
        end
    endtask : pin_chk

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end

    // Main sequence
    initial begin
        int          i, n;
        logic [5:0]  codes, exp_pair;
        logic [15:0] cfg;
        void'($urandom(40276));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_GEN_CFG, {16'h0, GEN_CFG_RESET}, RESP_OKAY);
        rd(8'h08, 32'h0, RESP_SLVERR);
        wr(8'h0c, 32'hffff, 4'hf, RESP_SLVERR);
        wr(ADDR_STATUS, 32'hffff, 4'hf, RESP_OKAY);
        for (i = 0; i < 10; i++) begin
            codes = (i < 4) ? {3{i[1:0]}} : 6'($urandom);
            cfg = GEN_CFG_RESET | {1'($urandom),
                  (i < 4) ? i[0] : 1'($urandom), codes, 8'h00};
            wr(ADDR_GEN_CFG, {16'h0, cfg}, 4'h3, RESP_OKAY);
            rd(ADDR_GEN_CFG, {16'h0, cfg}, RESP_OKAY);
            @(negedge clk);
            for (n = 0; n < 3; n++)
                exp_pair[2*n+:2] = pick_src(n, codes[2*n+:2]);
            chk("phase_src", 32'(exp_pair), 32'(phase_src));
            chk("neutral_sel", 32'(cfg[FLD_NEUTRAL]),
                32'(neutral_sel));
        end
        // Flip only the reserved bit: nothing downstream may move
        cfg = cfg ^ 16'h8000;
        wr(ADDR_GEN_CFG, {16'h0, cfg}, 4'h3, RESP_OKAY);
        rd(ADDR_GEN_CFG, {16'h0, cfg}, RESP_OKAY);
        @(negedge clk);
        chk("rsvd_pair", 32'(exp_pair), 32'(phase_src));
        chk("rsvd_capture", 32'h0, 32'(cap_en));
        settle_chk(1'b1, S_LONG);
        settle_chk(1'b0, S_SHORT);
        pin_chk(1'b1);
        rd(ADDR_STATUS, (32'h1 << STS_SETTLED) |
           (32'h1 << STS_CAPTURE), RESP_OKAY);
        pin_chk(1'b0);
        wr(ADDR_GEN_CFG, 32'h0000_70f0, 4'h3, RESP_OKAY);
        @(negedge clk);
        chk("soft_active", 32'h1, 32'(soft_act));
        rd(ADDR_GEN_CFG, 32'h0000_70f0, RESP_OKAY);
        n = 0;
        while (soft_act !== 1'b0 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk("soft_done", 32'h0, 32'(soft_act));
        rd(ADDR_GEN_CFG, {16'h0, GEN_CFG_RESET}, RESP_OKAY);
        @(negedge clk);
        chk("neutral_after", 32'h0, 32'(neutral_sel));
        chk("capture_after", 32'h0, 32'(cap_en));
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule : meter_config_control_test
`default_nettype wire
